// [rtl/chk_cfg.svh]
// Offsets, field positions, reset values and timing counts of the checkpoint block.
// Assumes byte addressing on an Avalon-MM slave with 32-bit data.
`ifndef CHK_CFG_SVH
`define CHK_CFG_SVH
`define CHK_OFS_SOURCE 8'h00
`define CHK_OFS_MODE 8'h04
`define CHK_OFS_TRIGOUT 8'h08
`define CHK_OFS_SEQCFG 8'h0C
`define CHK_OFS_CLKSEL 8'h10
`define CHK_OFS_STATUS 8'h14
`define CHK_OFS_ITEM0 8'h20
`define CHK_SRC_OFF_BIT 8
`define CHK_MODE_KIND_LSB 0
`define CHK_MODE_COUNT_LSB 4
`define CHK_SEQ_FIELD_W 4
`define CHK_RST_SOURCE 6'h00
`define CHK_RST_KIND 2'h0
`define CHK_RST_COUNT 3'h1
`define CHK_RST_CLKSEL 1'b0
`define CHK_NUM_SOURCES 6
`define CHK_NUM_ITEMS 5
`define CHK_GEN_ITEMS 13
`define CHK_SEQ_MAX_SERIAL 4
`define CHK_SEQ_MAX_PARALLEL 7
`define CHK_CLK_PERIOD_NS 10
`define CHK_EMU_RESET_NS 200
`define CHK_EMU_RESET_CYC ((`CHK_EMU_RESET_NS + `CHK_CLK_PERIOD_NS - 1) / `CHK_CLK_PERIOD_NS)
`endif

// [rtl/chk_pkg.sv]
// Types shared by the checkpoint capture block, its checker and its bench.
// Assumes the constants of chk_cfg.svh.
package chk_pkg;
  // Kind of check data captured on a checkpoint.
  typedef enum logic [1:0] {
    KIND_GENERAL,
    KIND_SPECIAL,
    KIND_DATA_MEM,
    KIND_NONE
  } capture_kind_t;

  // Controller states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SUSPEND,
    ST_FETCH,
    ST_WAIT,
    ST_RESUME
  } cap_state_t;

  // One word asked of the emulated processor.
  typedef struct packed {
    capture_kind_t kind;
    logic [15:0] sel;
  } fetch_req_t;

  // One trace-memory record written by a checkpoint.
  typedef struct packed {
    logic check_tag;
    capture_kind_t kind;
    logic [3:0] item;
    logic [15:0] data;
  } trace_rec_t;
endpackage

// [rtl/chk_fifo.sv]
// Small flip-flop FIFO between check-data fetch and trace memory.
// Assumes one clock; both sides use valid and ready.
module chk_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Fill side.
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side.
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready,
  // Fill level.
  output logic [$clog2(DEPTH+1)-1:0] o_level
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);

  // The pointer arithmetic wraps only for powers of two.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("chk_fifo DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  // Full and empty follow the count, so neither side is misled.
  assign o_in_ready = (count != CW'(DEPTH));
  assign o_out_valid = (count != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_ptr];
  assign o_level = count;

  // Storage is written without reset; validity comes from the count.
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // Pointers and count.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end
endmodule

// [rtl/checkpoint_trace_capture.sv]
// Checkpoint capture logic of an in-circuit emulator, with its register file on Avalon-MM.
// Assumes event match pulses, run and halt status come from logic on i_clk, and that the
// emulated processor answers each fetch with a one-cycle acknowledge carrying the data.
//
// Functional notes
// - Event suspends run, stores data, then resumes.
// - Selected event sources are ORed together.
// - Six sources: four address, two sequence.
// - No capture during break delay interval.
// - General mode captures full register set.
// - Special mode captures up to five registers.
// - Data mode captures up to five exact addresses.
// - Trigger-output address events never trigger checkpoints.
// - Pending captures finish before interrupt service.
// - Source and data selection read back.
// - Clock source mux, target or internal, readable.
// - Clock source change resets emulation device.
// - Sequence register: four serial, seven parallel.
//
// Chosen here: the register offsets and register access over Avalon-MM.
`include "chk_cfg.svh"

module checkpoint_trace_capture #(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Avalon-MM slave.
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Event sources.
  input wire logic [3:0] i_addr_event,
  input wire logic [1:0][6:0] i_seq_match,
  // Emulated processor status and control.
  input wire logic i_run,
  input wire logic i_break_delay_active,
  input wire logic i_halted,
  output logic o_suspend,
  output logic o_irq_hold,
  // Check-data fetch from the emulated processor.
  output logic o_fetch_valid,
  output chk_pkg::fetch_req_t o_fetch,
  input wire logic i_fetch_ack,
  input wire logic [15:0] i_fetch_data,
  // Trace-memory write port.
  output logic o_trace_valid,
  output chk_pkg::trace_rec_t o_trace_rec,
  input wire logic i_trace_ready,
  // Clock source and emulation reset.
  output logic o_clk_sel_target,
  output logic o_emu_reset
);
  import chk_pkg::*;

  localparam int NSRC = `CHK_NUM_SOURCES;
  localparam int NITEM = `CHK_NUM_ITEMS;
  localparam int LW = $clog2(FIFO_DEPTH+1);
  localparam int RST_CYC = `CHK_EMU_RESET_CYC;

  // The status register has room for the level of a FIFO of at most eight words.
  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 8) begin : g_bad_depth
    $error("FIFO_DEPTH must lie between 2 and 8");
  end

  // Software-visible state.
  logic [NSRC-1:0] source_sel;
  capture_kind_t cap_kind;
  logic [2:0] cap_count;
  logic [1:0] trig_out_assign;
  logic [1:0] seq_parallel;
  logic [1:0][2:0] seq_count;
  logic [15:0] item_sel [NITEM];
  logic clk_sel_target;
  logic [7:0] capture_total;

  // Bus slave state.
  logic bus_ack;
  logic bus_req;
  logic wr_en;
  logic [31:0] next_readdata;

  // Trigger and controller state.
  logic [1:0] seq_fire;
  logic [1:0][2:0] seq_stage;
  logic [NSRC-1:0] event_vec;
  logic [NSRC-1:0] usable_sel;
  logic hit;
  logic [2:0] pending;
  logic start_cap;
  cap_state_t state;
  logic [3:0] item_idx;
  logic [3:0] item_last;
  logic [4:0] rst_cnt;

  // FIFO wiring.
  logic fifo_in_ready;
  logic [LW-1:0] fifo_level;
  trace_rec_t fifo_in;

  // Each access is answered one cycle after it appears, with read data held in a flop.
  assign bus_req = i_avs_read || i_avs_write;
  assign o_avs_waitrequest = bus_req && !bus_ack;
  assign wr_en = i_avs_write && bus_ack;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bus_ack <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      bus_ack <= bus_req && !bus_ack;
      if (i_avs_read && !bus_ack) begin
        o_avs_readdata <= next_readdata;
      end
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (i_avs_address)
      `CHK_OFS_SOURCE: next_readdata[NSRC-1:0] = source_sel;
      `CHK_OFS_MODE: begin
        next_readdata[`CHK_MODE_KIND_LSB +: 2] = cap_kind;
        next_readdata[`CHK_MODE_COUNT_LSB +: 3] = cap_count;
      end
      `CHK_OFS_TRIGOUT: next_readdata[1:0] = trig_out_assign;
      `CHK_OFS_SEQCFG: begin
        next_readdata[0] = seq_parallel[0];
        next_readdata[3:1] = seq_count[0];
        next_readdata[`CHK_SEQ_FIELD_W] = seq_parallel[1];
        next_readdata[`CHK_SEQ_FIELD_W+1 +: 3] = seq_count[1];
      end
      `CHK_OFS_CLKSEL: next_readdata[0] = clk_sel_target;
      `CHK_OFS_STATUS: begin
        next_readdata[0] = (state != ST_IDLE);
        next_readdata[1] = o_suspend;
        next_readdata[4:2] = pending;
        next_readdata[15:8] = capture_total;
        next_readdata[16 +: LW] = fifo_level;
      end
      default: begin
        for (int k = 0; k < NITEM; k++) begin
          if (i_avs_address == `CHK_OFS_ITEM0 + 8'(4 * k)) begin
            next_readdata[15:0] = item_sel[k];
          end
        end
      end
    endcase
  end

  // Checkpoint source selection; writing the off bit empties every selection.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      source_sel <= `CHK_RST_SOURCE;
    end else if (wr_en && i_avs_address == `CHK_OFS_SOURCE) begin
      if (i_avs_writedata[`CHK_SRC_OFF_BIT]) begin
        source_sel <= '0;
      end else begin
        source_sel <= i_avs_writedata[NSRC-1:0];
      end
    end
  end

  // Check-data kind and item count; the count is held to the range one to five.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cap_kind <= capture_kind_t'(`CHK_RST_KIND);
      cap_count <= `CHK_RST_COUNT;
    end else if (wr_en && i_avs_address == `CHK_OFS_MODE) begin
      cap_kind <= capture_kind_t'(i_avs_writedata[`CHK_MODE_KIND_LSB +: 2]);
      if (i_avs_writedata[`CHK_MODE_COUNT_LSB +: 3] == 3'h0) begin
        cap_count <= 3'h1;
      end else if (i_avs_writedata[`CHK_MODE_COUNT_LSB +: 3] > 3'(NITEM)) begin
        cap_count <= 3'(NITEM);
      end else begin
        cap_count <= i_avs_writedata[`CHK_MODE_COUNT_LSB +: 3];
      end
    end
  end

  // Trigger-output assignment and sequence-register configuration.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      trig_out_assign <= 2'h0;
      seq_parallel <= 2'h0;
      seq_count <= '0;
    end else if (wr_en) begin
      if (i_avs_address == `CHK_OFS_TRIGOUT) begin
        trig_out_assign <= i_avs_writedata[1:0];
      end
      if (i_avs_address == `CHK_OFS_SEQCFG) begin
        seq_parallel[0] <= i_avs_writedata[0];
        seq_count[0] <= i_avs_writedata[3:1];
        seq_parallel[1] <= i_avs_writedata[`CHK_SEQ_FIELD_W];
        seq_count[1] <= i_avs_writedata[`CHK_SEQ_FIELD_W+1 +: 3];
      end
    end
  end

  // Special-register numbers or exact data-memory addresses; no mask is kept.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int k = 0; k < NITEM; k++) begin
        item_sel[k] <= 16'h0000;
      end
    end else if (wr_en) begin
      for (int k = 0; k < NITEM; k++) begin
        if (i_avs_address == `CHK_OFS_ITEM0 + 8'(4 * k)) begin
          item_sel[k] <= i_avs_writedata[15:0];
        end
      end
    end
  end

  // Clock source; a real change starts an emulation reset, a rewrite of the same value not.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      clk_sel_target <= `CHK_RST_CLKSEL;
      rst_cnt <= 5'h00;
    end else begin
      if (wr_en && i_avs_address == `CHK_OFS_CLKSEL) begin
        clk_sel_target <= i_avs_writedata[0];
      end
      if (wr_en && i_avs_address == `CHK_OFS_CLKSEL && i_avs_writedata[0] != clk_sel_target) begin
        rst_cnt <= 5'(RST_CYC);
      end else if (rst_cnt != 5'h00) begin
        rst_cnt <= rst_cnt - 5'h01;
      end
    end
  end

  assign o_clk_sel_target = clk_sel_target;
  assign o_emu_reset = (rst_cnt != 5'h00);

  // Sequence-event registers: serial mode steps through up to four matches in order,
  // parallel mode fires on any of up to seven enabled matches.
  for (genvar g = 0; g < 2; g++) begin : g_seq
    logic [2:0] serial_len;
    logic [6:0] par_mask;
    assign serial_len = (seq_count[g] > 3'(`CHK_SEQ_MAX_SERIAL)) ?
                        3'(`CHK_SEQ_MAX_SERIAL) : seq_count[g];
    assign par_mask = 7'((8'h01 << seq_count[g]) - 8'h01);
    always_comb begin
      if (seq_parallel[g]) begin
        seq_fire[g] = |(i_seq_match[g] & par_mask);
      end else begin
        seq_fire[g] = (serial_len != 3'h0) && i_seq_match[g][seq_stage[g]] &&
                      (seq_stage[g] == serial_len - 3'h1);
      end
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        seq_stage[g] <= 3'h0;
      end else if (seq_parallel[g] || serial_len == 3'h0 || seq_fire[g]) begin
        seq_stage[g] <= 3'h0;
      end else if (i_seq_match[g][seq_stage[g]]) begin
        seq_stage[g] <= seq_stage[g] + 3'h1;
      end
    end
  end

  // Address events three and four are withheld while they drive the trigger output.
  assign event_vec = {seq_fire, i_addr_event};
  assign usable_sel = source_sel & ~{2'b00, trig_out_assign, 2'b00};
  // Any one selected source suffices; the break delay interval blocks capture.
  assign hit = |(usable_sel & event_vec) && i_run && !i_break_delay_active;

  // A capture starts from idle, or straight after a resume while more are pending.
  assign start_cap = (pending != 3'h0) && (state == ST_IDLE || (state == ST_RESUME && !i_halted));

  // Pending captures; a new hit in the cycle a capture starts is still counted.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pending <= 3'h0;
    end else if (hit && !start_cap && pending != 3'h7) begin
      pending <= pending + 3'h1;
    end else if (start_cap && !hit) begin
      pending <= pending - 3'h1;
    end
  end

  // Interrupts are held off until every pending capture is done.
  assign o_irq_hold = (pending != 3'h0) || (state != ST_IDLE);

  // Last item index of the configured kind; the none kind still fetches a single word.
  assign item_last = (cap_kind == KIND_GENERAL) ? 4'(`CHK_GEN_ITEMS - 1) :
                     (cap_kind == KIND_NONE) ? 4'h0 : 4'(cap_count - 3'h1);

  // Controller: suspend, fetch each item into the FIFO, then release the processor.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= ST_IDLE;
      item_idx <= 4'h0;
      capture_total <= 8'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_cap) begin
            state <= ST_SUSPEND;
          end
        end
        ST_SUSPEND: begin
          item_idx <= 4'h0;
          if (i_halted) begin
            state <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (fifo_in_ready) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (i_fetch_ack) begin
            if (item_idx == item_last) begin
              state <= ST_RESUME;
              capture_total <= capture_total + 8'h01;
            end else begin
              item_idx <= item_idx + 4'h1;
              state <= ST_FETCH;
            end
          end
        end
        ST_RESUME: begin
          if (start_cap) begin
            state <= ST_SUSPEND;
          end else if (!i_halted) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign o_suspend = (state == ST_SUSPEND) || (state == ST_FETCH) || (state == ST_WAIT);
  // The fetch is only raised while the FIFO has room, so an acknowledged word always fits.
  assign o_fetch_valid = (state == ST_WAIT);
  assign o_fetch = {cap_kind, (cap_kind == KIND_GENERAL) ? {12'h000, item_idx} :
                    (cap_kind == KIND_NONE) ? 16'h0000 : item_sel[item_idx[2:0]]};
  // Record for trace memory, marked as check data with its kind.
  assign fifo_in = {1'b1, cap_kind, item_idx, i_fetch_data};

  chk_fifo #(
    .WIDTH($bits(trace_rec_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_in_valid(i_fetch_ack && state == ST_WAIT),
    .i_in_data(fifo_in),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(o_trace_valid),
    .o_out_data(o_trace_rec),
    .i_out_ready(i_trace_ready),
    .o_level(fifo_level)
  );
endmodule

// [tb/checkpoint_trace_capture_chk.sv]
// Checker for the capture block: bus wait state, fetch handshake, trace tags, clock reset.
// Assumes it is bound to checkpoint_trace_capture and sees only its ports.
`include "chk_cfg.svh"
module checkpoint_trace_capture_chk
  import chk_pkg::*;
(
  // Clock, reset and bus.
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  // Capture side.
  input wire logic i_fetch_ack,
  input wire logic o_suspend,
  input wire logic o_irq_hold,
  input wire logic o_fetch_valid,
  input wire chk_pkg::fetch_req_t o_fetch,
  input wire logic o_trace_valid,
  input wire chk_pkg::trace_rec_t o_trace_rec,
  // Clock source.
  input wire logic o_clk_sel_target,
  input wire logic o_emu_reset
);
  logic [7:0] rst_len;
  // The reset pulse is too long for a repetition, so its length is counted here.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) rst_len <= 8'h00;
    else rst_len <= o_emu_reset ? rst_len + 8'h01 : 8'h00;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_access;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_waiting;
    o_fetch_valid && !i_fetch_ack;
  endsequence
  property p_one_wait;
    s_access |=> !o_avs_waitrequest;
  endproperty
  property p_fetch_holds;
    s_waiting |=> o_fetch_valid && $stable(o_fetch);
  endproperty
  property p_fetch_start;
    $rose(o_fetch_valid) |-> $past(o_suspend);
  endproperty
  property p_fetch_irq;
    o_fetch_valid |-> o_suspend && o_irq_hold;
  endproperty
  property p_suspend_irq;
    o_suspend |-> o_irq_hold;
  endproperty
  property p_gen_range;
    o_fetch_valid && o_fetch.kind == KIND_GENERAL |-> o_fetch.sel < `CHK_GEN_ITEMS;
  endproperty
  property p_tag;
    o_trace_valid |-> o_trace_rec.check_tag && o_trace_rec.item < 4'hD;
  endproperty
  property p_clk_reset;
    $changed(o_clk_sel_target) |-> ##[0:1] o_emu_reset;
  endproperty
  property p_reset_len;
    $fell(o_emu_reset) |-> rst_len == `CHK_EMU_RESET_CYC;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("bus access waited more than one cycle");
  a_fetch_holds: assert property (p_fetch_holds)
    else $error("fetch request changed before acknowledge");
  a_fetch_start: assert property (p_fetch_start)
    else $error("fetch raised without suspension");
  a_fetch_irq: assert property (p_fetch_irq)
    else $error("fetch outside suspension or interrupt hold");
  a_suspend_irq: assert property (p_suspend_irq)
    else $error("interrupt not held during capture");
  a_gen_range: assert property (p_gen_range)
    else $error("general item out of range");
  a_tag: assert property (p_tag)
    else $error("trace record not tagged as check data");
  a_clk_reset: assert property (p_clk_reset)
    else $error("clock change without emulation reset");
  a_reset_len: assert property (p_reset_len)
    else $error("emulation reset pulse has wrong length");
endmodule
bind checkpoint_trace_capture checkpoint_trace_capture_chk u_chk (.*);

// [tb/chk_proc_model.sv]
// Behavioural emulated processor: halts on suspend and answers check-data fetches.
// Assumes the fetch handshake of the capture block, one acknowledge pulse per request.
module chk_proc_model
  import chk_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Slow answers when set.
  input wire logic i_slow,
  // Capture block side.
  input wire logic i_suspend,
  input wire logic i_fetch_valid,
  input wire chk_pkg::fetch_req_t i_fetch,
  output logic o_halted,
  output logic o_fetch_ack,
  output logic [15:0] o_fetch_data
);
  logic [1:0] gap;
  // Halt lags suspend by a cycle, as a core finishing its instruction would.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) o_halted <= 1'b0;
    else o_halted <= i_suspend;
  end
  // One answer per request; idle data lines toggle so no stale value can pass.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gap <= 2'h0;
      o_fetch_ack <= 1'b0;
      o_fetch_data <= 16'h0000;
    end else if (i_fetch_valid && !o_fetch_ack && (gap == 2'h0 || !i_slow)) begin
      o_fetch_ack <= 1'b1;
      o_fetch_data <= {i_fetch.kind, i_fetch.sel[13:0]} ^ 16'h5A5A;
      gap <= 2'h3;
    end else begin
      o_fetch_ack <= 1'b0;
      o_fetch_data <= ~o_fetch_data;
      gap <= (gap != 2'h0 && i_fetch_valid) ? gap - 2'h1 : gap;
    end
  end
endmodule

// [tb/tb.sv]
// Self-checking bench for the checkpoint capture block over its Avalon-MM registers.
// Assumes the design files and the processor model are compiled before it.
`include "chk_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import chk_pkg::*;
  logic i_clk, i_rst_b, rd, wr, run, bdly, tready, slow, halted, ack, wreq, susp, irqh;
  logic fvalid, tvalid, clk_tgt, emu_rst;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rdq;
  logic [3:0] aev;
  logic [1:0][6:0] seq;
  logic [15:0] fdata;
  fetch_req_t freq;
  trace_rec_t trec;
  trace_rec_t q[$];
  int mismatches, num_checks, n;
  logic [15:0] itm [5] = '{16'h0031, 16'h0142, 16'h0253, 16'h0364, 16'h0475};
  checkpoint_trace_capture DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdq),
    .o_avs_waitrequest(wreq), .i_addr_event(aev), .i_seq_match(seq), .i_run(run),
    .i_break_delay_active(bdly), .i_halted(halted), .o_suspend(susp), .o_irq_hold(irqh),
    .o_fetch_valid(fvalid), .o_fetch(freq), .i_fetch_ack(ack), .i_fetch_data(fdata),
    .o_trace_valid(tvalid), .o_trace_rec(trec), .i_trace_ready(tready),
    .o_clk_sel_target(clk_tgt), .o_emu_reset(emu_rst));
  chk_proc_model u_model (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_slow(slow), .i_suspend(susp),
    .i_fetch_valid(fvalid), .i_fetch(freq), .o_halted(halted), .o_fetch_ack(ack),
    .o_fetch_data(fdata));
  // Free-running 100 MHz clock.
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Records are taken at the falling edge, where valid and ready have settled.
  always @(negedge i_clk) begin
    if (tvalid === 1'b1 && tready === 1'b1) q.push_back(trec);
  end
  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // One bus access, held until waitrequest is sampled low at a rising edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t = 0;
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    do begin
      @(posedge i_clk);
      t++;
    end while (wreq !== 1'b0 && t < 50);
    if (t >= 50) begin
      mismatches++;
      conclude();
    end
    rdata = rdq;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rdata);
  endtask
  task automatic pulse(input logic [3:0] a, input logic [13:0] s);
    @(posedge i_clk);
    aev <= a;
    seq <= s;
    @(posedge i_clk);
    aev <= 4'h0;
    seq <= 14'h0000;
  endtask
  // Waits for ten quiet cycles, then compares every record with its expected value.
  task automatic expect_recs(input capture_kind_t k, input int m, input int caps);
    int quiet = 0;
    int t = 0;
    trace_rec_t e;
    logic [15:0] sel;
    while (quiet < 10 && t < 3000) begin
      @(negedge i_clk);
      t++;
      quiet = (susp === 1'b0 && tvalid === 1'b0) ? quiet + 1 : 0;
    end
    if (t >= 3000) begin
      mismatches++;
      conclude();
    end
    chk("record count", m * caps, q.size());
    for (int i = 0; i < m * caps && i < q.size(); i++) begin
      sel = (k == KIND_GENERAL) ? 16'(i % m) : itm[i % m];
      e = {1'b1, k, 4'(i % m), {k, sel[13:0]} ^ 16'h5A5A};
      chk("trace record", 32'(e), 32'(q[i]));
    end
    q.delete();
  endtask
  task automatic count_reset(output int c);
    c = 0;
    repeat (40) begin
      @(negedge i_clk);
      if (emu_rst === 1'b1) c++;
    end
  endtask
  // Main sequence.
  initial begin
    {i_rst_b, rd, wr, bdly, slow, addr, wdata, aev, seq} = '0;
    {run, tready} = 2'b11;
    mismatches = 0;
    num_checks = 0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd_chk(`CHK_OFS_SOURCE, 32'h0, "source");
    rd_chk(`CHK_OFS_MODE, 32'h10, "mode");
    rd_chk(`CHK_OFS_CLKSEL, 32'h0, "clock select");
    bus(1'b1, 8'hFC, 32'hFFFFFFFF);
    rd_chk(8'hFC, 32'h0, "unmapped");
    bus(1'b1, `CHK_OFS_SOURCE, 32'h3F);
    rd_chk(`CHK_OFS_SOURCE, 32'h3F, "source");
    bus(1'b1, `CHK_OFS_SOURCE, 32'h13F);
    rd_chk(`CHK_OFS_SOURCE, 32'h0, "source after off");
    pulse(4'hF, 14'h3FFF);
    expect_recs(KIND_GENERAL, 13, 0);
    // Unselected source, then a selected one while trace memory stalls the FIFO.
    bus(1'b1, `CHK_OFS_SOURCE, 32'h02);
    pulse(4'h1, 14'h0);
    expect_recs(KIND_GENERAL, 13, 0);
    @(posedge i_clk);
    tready <= 1'b0;
    pulse(4'h2, 14'h0);
    repeat (60) @(posedge i_clk);
    bus(1'b0, `CHK_OFS_STATUS, 32'h0);
    chk("fifo level", 32'h4, 32'(rdata[18:16]));
    chk("suspend", 32'h1, 32'(susp));
    tready <= 1'b1;
    expect_recs(KIND_GENERAL, 13, 1);
    // Hits during the break delay or outside real-time run are ignored.
    @(posedge i_clk);
    bdly <= 1'b1;
    pulse(4'h2, 14'h0);
    bdly <= 1'b0;
    run <= 1'b0;
    pulse(4'h2, 14'h0);
    run <= 1'b1;
    expect_recs(KIND_GENERAL, 13, 0);
    // Special registers; the third address event is blocked while it drives the output.
    for (int i = 0; i < 5; i++) bus(1'b1, `CHK_OFS_ITEM0 + 8'(4 * i), {16'h0, itm[i]});
    bus(1'b1, `CHK_OFS_MODE, 32'h51);
    bus(1'b1, `CHK_OFS_TRIGOUT, 32'h1);
    bus(1'b1, `CHK_OFS_SOURCE, 32'h04);
    pulse(4'h4, 14'h0);
    expect_recs(KIND_SPECIAL, 5, 0);
    bus(1'b1, `CHK_OFS_TRIGOUT, 32'h0);
    slow <= 1'b1;
    pulse(4'h4, 14'h0);
    expect_recs(KIND_SPECIAL, 5, 1);
    rd_chk(`CHK_OFS_MODE, 32'h51, "mode");
    // Data memory with too many items asked; two hits back to back both complete.
    bus(1'b1, `CHK_OFS_MODE, 32'h72);
    pulse(4'h4, 14'h0);
    pulse(4'h4, 14'h0);
    expect_recs(KIND_DATA_MEM, 5, 2);
    // Sequence events are configured before they are selected.
    bus(1'b1, `CHK_OFS_SEQCFG, 32'hF4);
    bus(1'b1, `CHK_OFS_MODE, 32'h11);
    bus(1'b1, `CHK_OFS_SOURCE, 32'h30);
    pulse(4'h0, 14'h0002);
    expect_recs(KIND_SPECIAL, 1, 0);
    pulse(4'h0, 14'h0001);
    pulse(4'h0, 14'h0002);
    expect_recs(KIND_SPECIAL, 1, 1);
    pulse(4'h0, 14'h2000);
    expect_recs(KIND_SPECIAL, 1, 1);
    // The target clock sockets are taken as fitted before the target clock is chosen.
    bus(1'b1, `CHK_OFS_CLKSEL, 32'h1);
    count_reset(n);
    chk("reset length", `CHK_EMU_RESET_CYC, n);
    chk("clock pin", 32'h1, 32'(clk_tgt));
    rd_chk(`CHK_OFS_CLKSEL, 32'h1, "clock select");
    bus(1'b1, `CHK_OFS_CLKSEL, 32'h1);
    count_reset(n);
    chk("reset on rewrite", 32'h0, n);
    conclude();
  end
endmodule
